/* src/macd_pkg.sv */
package macd_pkg;

  localparam logic [3:0]  LINE_A       = 4'ha;
  localparam int          OP_TOP_POS   = 12;
  localparam int          OPMODE_POS   = 9;
  localparam int          EA_MODE_POS  = 3;
  localparam int          EXT_RY_POS   = 12;
  localparam int          EXT_SZ_POS   = 11;
  localparam int          EXT_SF_POS   = 9;
  localparam int          EXT_DIR_POS  = 8;
  localparam int          EXT_ULY_POS  = 7;
  localparam int          EXT_ULX_POS  = 6;
  localparam int          EXT_MAM_POS  = 5;
  localparam logic [2:0]  SEL_ACC      = 3'h0;
  localparam logic [2:0]  SEL_STAT     = 3'h4;
  localparam logic [2:0]  SEL_MASK     = 3'h6;
  localparam logic [1:0]  MV_LOAD      = 2'h0;
  localparam logic [1:0]  MV_STORE     = 2'h2;
  localparam logic [2:0]  EA_DREG      = 3'h0;
  localparam logic [2:0]  EA_AREG      = 3'h1;
  localparam logic [2:0]  EA_IND       = 3'h2;
  localparam logic [2:0]  EA_POSTINC   = 3'h3;
  localparam logic [2:0]  EA_PREDEC    = 3'h4;
  localparam logic [2:0]  EA_DISP16    = 3'h5;
  localparam logic [2:0]  EA_SPECIAL   = 3'h7;
  localparam logic [2:0]  EA_IMM_REG   = 3'h4;
  localparam logic [1:0]  SF_NONE      = 2'h0;
  localparam logic [1:0]  SF_LEFT      = 2'h1;
  localparam logic [1:0]  SF_RIGHT     = 2'h3;
  localparam int          ST_OMC       = 7;
  localparam int          ST_SU        = 6;
  localparam int          ST_N         = 3;
  localparam int          ST_Z         = 2;
  localparam int          ST_V         = 1;
  localparam int          ST_C         = 0;
  localparam logic [31:0] ACC_RESET    = 32'h0;
  localparam logic [7:0]  STAT_RESET   = 8'h0;
  localparam logic [15:0] MASK_RESET   = 16'hffff;
  localparam logic [15:0] ONES_HI      = 16'hffff;

  typedef struct packed {
    logic       valid;
    logic [15:0] op;
    logic [15:0] ext;
    logic [31:0] src_x;
    logic [31:0] src_y;
    logic [31:0] ea_addr;
    logic [31:0] ea_data;
  } macd_req_s;

  typedef struct packed {
    logic        we;
    logic [3:0]  idx;
    logic [31:0] data;
  } macd_wb_s;

  typedef struct packed {
    logic       we;
    logic [3:0] nzvc;
  } macd_cc_s;

  typedef struct packed {
    logic [3:0] rx;
    logic [3:0] ry;
    logic [3:0] rw;
    logic [2:0] ea_mode;
    logic [2:0] ea_reg;
    logic       size_long;
    logic [1:0] shift;
    logic       subtract;
    logic       y_upper;
    logic       x_upper;
    logic       masked;
  } macd_fields_s;

endpackage

/* src/macd_field_decode.sv */
`timescale 1ns/1ps
module macd_field_decode (
  input  wire logic [15:0]           op_i,
  input  wire logic [15:0]           ext_i,
  output macd_pkg::macd_fields_s     fld_o
);

  always_comb begin
    fld_o           = '0;
    fld_o.rx        = ext_i[3:0];
    fld_o.ry        = ext_i[macd_pkg::EXT_RY_POS +: 4];
    fld_o.rw        = {op_i[6], op_i[macd_pkg::OPMODE_POS +: 3]};
    fld_o.ea_mode   = op_i[macd_pkg::EA_MODE_POS +: 3];
    fld_o.ea_reg    = op_i[2:0];
    fld_o.size_long = ext_i[macd_pkg::EXT_SZ_POS];
    fld_o.shift     = ext_i[macd_pkg::EXT_SF_POS +: 2];
    fld_o.subtract  = ext_i[macd_pkg::EXT_DIR_POS];
    fld_o.y_upper   = ext_i[macd_pkg::EXT_ULY_POS];
    fld_o.x_upper   = ext_i[macd_pkg::EXT_ULX_POS];
    fld_o.masked    = ext_i[macd_pkg::EXT_MAM_POS];
  end

endmodule

/* src/macd_unit.sv */
`timescale 1ns/1ps
// Overview of operation
// - Decode only opcodes with top nibble 1010
// - Y source from extension bits 15..12
// - Load destination from bits 6,11,10,9
// - Load forms accept only four address modes
// - Size bit: 0 word, 1 long operands
// - Shift: 00 none, 01 left, 11 right
// - Word ops pick upper or lower halves
// - Mask bit selects masked addressing
// - Masked: AND low address half with mask
// - Load forms write fetched long to destination
// - Multiply sets N, Z, V sticky, clears C
// - Move from accumulator copies all 32 bits
// - Move from status zero-extends eight bits
// - Move from mask one-extends sixteen bits
// - Move to accumulator sets N Z, clears V C
// - Status bits 3..0 copied to condition codes
// - Move to status takes low byte fields
// - Move to mask loads low sixteen bits
module macd_unit (
  input  wire logic                  mclk_i,
  input  wire logic                  rst_i,
  input  wire macd_pkg::macd_req_s   req_i,
  output macd_pkg::macd_wb_s         wb_o,
  output macd_pkg::macd_cc_s         cc_o,
  output logic [31:0]                mem_addr_o,
  output logic                       mem_addr_valid_o,
  output logic                       illegal_o,
  output logic                       done_o,
  output logic [31:0]                product_sum_reg_o,
  output logic [7:0]                 multiply_unit_status_o,
  output logic [15:0]                address_mask_o
);

  typedef enum logic [5:0] {
    MACD_OP_NONE   = 6'h01,
    MACD_OP_ARITH  = 6'h02,
    MACD_OP_LOAD   = 6'h04,
    MACD_OP_MVTO   = 6'h08,
    MACD_OP_MVFROM = 6'h10,
    MACD_OP_CCR    = 6'h20
  } macd_op_e;

  macd_pkg::macd_fields_s fld;
  macd_op_e               kind;
  logic [15:0]            op;
  logic [2:0]             sel;
  logic [1:0]             dir;
  logic                   ea_ok_load;
  logic                   ea_ok_move;
  logic [31:0]            move_src;
  logic [31:0]            xop;
  logic [31:0]            yop;
  logic [31:0]            prod;
  logic [31:0]            scaled;
  logic [32:0]            acc_sum;
  logic                   ovf;
  logic [31:0]            acc_next;
  logic [7:0]             mv_flags;

  logic [31:0]            product_sum_reg_q;
  logic [7:0]             multiply_unit_status_q;
  logic [15:0]            address_mask_q;

  macd_field_decode u_fields (
    .op_i  (req_i.op),
    .ext_i (req_i.ext),
    .fld_o (fld)
  );

  function automatic logic [31:0] half_pick(input logic [31:0] v, input logic upper, input logic long_op);
    logic [31:0] r;
    r = v;
    if (!long_op) begin
      r = upper ? {v[31:16], 16'h0000} : {v[15:0], 16'h0000};
    end
    return r;
  endfunction

  function automatic logic [7:0] nz_flags(input logic [31:0] v);
    logic [7:0] f;
    f           = 8'h00;
    f[macd_pkg::ST_N] = v[31];
    f[macd_pkg::ST_Z] = (v == 32'h0);
    return f;
  endfunction

  assign op  = req_i.op;
  assign sel = op[macd_pkg::OPMODE_POS +: 3];
  assign dir = op[7:6];

  always_comb begin
    ea_ok_load = 1'b0;
    unique case (fld.ea_mode)
      macd_pkg::EA_IND,
      macd_pkg::EA_POSTINC,
      macd_pkg::EA_PREDEC,
      macd_pkg::EA_DISP16: ea_ok_load = 1'b1;
      default:             ea_ok_load = 1'b0;
    endcase
  end

  assign ea_ok_move = (fld.ea_mode == macd_pkg::EA_DREG) || (fld.ea_mode == macd_pkg::EA_AREG) ||
                      (fld.ea_mode == macd_pkg::EA_SPECIAL && fld.ea_reg == macd_pkg::EA_IMM_REG);
  assign move_src   = req_i.ea_data;
  assign mv_flags   = nz_flags(move_src);

  always_comb begin
    kind = MACD_OP_NONE;
    if (op[macd_pkg::OP_TOP_POS +: 4] == macd_pkg::LINE_A) begin
      if (!op[8]) begin
        if (!op[7] && op[5:4] == 2'b00) begin
          kind = MACD_OP_ARITH;
        end else if (op[7] && ea_ok_load) begin
          kind = MACD_OP_LOAD;
        end
      end else if (dir == macd_pkg::MV_STORE && op[5:4] == 2'b00) begin
        if (sel == macd_pkg::SEL_ACC || sel == macd_pkg::SEL_STAT || sel == macd_pkg::SEL_MASK) begin
          kind = MACD_OP_MVFROM;
        end
      end else if (dir == 2'b11 && sel == macd_pkg::SEL_STAT && op[5:0] == 6'h00) begin
        kind = MACD_OP_CCR;
      end else if (dir == macd_pkg::MV_LOAD && ea_ok_move) begin
        if (sel == macd_pkg::SEL_ACC || sel == macd_pkg::SEL_STAT || sel == macd_pkg::SEL_MASK) begin
          kind = MACD_OP_MVTO;
        end
      end
    end
  end

  always_comb begin
    xop = half_pick(req_i.src_x, fld.x_upper, fld.size_long);
    yop = half_pick(req_i.src_y, fld.y_upper, fld.size_long);
    if (fld.size_long) begin
      prod = 32'(signed'(xop) * signed'(yop));
    end else begin
      prod = 32'(signed'({{16{xop[31]}}, xop[31:16]}) * signed'({{16{yop[31]}}, yop[31:16]}));
    end
    unique case (fld.shift)
      macd_pkg::SF_LEFT:  scaled = {prod[30:0], 1'b0};
      macd_pkg::SF_RIGHT: scaled = {prod[31], prod[31:1]};
      default:            scaled = prod;
    endcase
    if (fld.subtract) begin
      acc_sum = {product_sum_reg_q[31], product_sum_reg_q} - {scaled[31], scaled};
    end else begin
      acc_sum = {product_sum_reg_q[31], product_sum_reg_q} + {scaled[31], scaled};
    end
    ovf      = acc_sum[32] ^ acc_sum[31];
    acc_next = acc_sum[31:0];
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      product_sum_reg_q <= macd_pkg::ACC_RESET;
    end else if (req_i.valid) begin
      if (kind == MACD_OP_ARITH || kind == MACD_OP_LOAD) begin
        product_sum_reg_q <= acc_next;
      end else if (kind == MACD_OP_MVTO && sel == macd_pkg::SEL_ACC) begin
        product_sum_reg_q <= move_src;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      multiply_unit_status_q <= macd_pkg::STAT_RESET;
    end else if (req_i.valid) begin
      if (kind == MACD_OP_ARITH || kind == MACD_OP_LOAD) begin
        multiply_unit_status_q[macd_pkg::ST_N] <= acc_next[31];
        multiply_unit_status_q[macd_pkg::ST_Z] <= (acc_next == 32'h0);
        multiply_unit_status_q[macd_pkg::ST_V] <= multiply_unit_status_q[macd_pkg::ST_V] | ovf;
        multiply_unit_status_q[macd_pkg::ST_C] <= 1'b0;
        multiply_unit_status_q[5:4]           <= 2'b00;
      end else if (kind == MACD_OP_MVTO && sel == macd_pkg::SEL_ACC) begin
        multiply_unit_status_q[5:0] <= mv_flags[5:0];
      end else if (kind == MACD_OP_MVTO && sel == macd_pkg::SEL_STAT) begin
        multiply_unit_status_q <= {move_src[macd_pkg::ST_OMC], move_src[macd_pkg::ST_SU], 2'b00,
                                   move_src[macd_pkg::ST_N], move_src[macd_pkg::ST_Z],
                                   move_src[macd_pkg::ST_V], 1'b0};
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      address_mask_q <= macd_pkg::MASK_RESET;
    end else if (req_i.valid && kind == MACD_OP_MVTO && sel == macd_pkg::SEL_MASK) begin
      address_mask_q <= move_src[15:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wb_o <= '0;
    end else begin
      wb_o.we <= 1'b0;
      if (req_i.valid && kind == MACD_OP_LOAD) begin
        wb_o.we   <= 1'b1;
        wb_o.idx  <= fld.rw;
        wb_o.data <= req_i.ea_data;
      end else if (req_i.valid && kind == MACD_OP_MVFROM) begin
        wb_o.we  <= 1'b1;
        wb_o.idx <= op[3:0];
        unique case (sel)
          macd_pkg::SEL_ACC:  wb_o.data <= product_sum_reg_q;
          macd_pkg::SEL_STAT: wb_o.data <= {24'h000000, multiply_unit_status_q};
          default:            wb_o.data <= {macd_pkg::ONES_HI, address_mask_q};
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cc_o <= '0;
    end else begin
      cc_o.we <= req_i.valid && kind == MACD_OP_CCR;
      if (req_i.valid && kind == MACD_OP_CCR) begin
        cc_o.nzvc <= multiply_unit_status_q[3:0];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mem_addr_o       <= 32'h0;
      mem_addr_valid_o <= 1'b0;
    end else begin
      mem_addr_valid_o <= req_i.valid && kind == MACD_OP_LOAD;
      if (req_i.valid && kind == MACD_OP_LOAD) begin
        mem_addr_o <= fld.masked ? {req_i.ea_addr[31:16], req_i.ea_addr[15:0] & address_mask_q}
                                 : req_i.ea_addr;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      illegal_o <= 1'b0;
      done_o    <= 1'b0;
    end else begin
      illegal_o <= req_i.valid && kind == MACD_OP_NONE;
      done_o    <= req_i.valid && kind != MACD_OP_NONE;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      product_sum_reg_o      <= macd_pkg::ACC_RESET;
      multiply_unit_status_o <= macd_pkg::STAT_RESET;
      address_mask_o         <= macd_pkg::MASK_RESET;
    end else begin
      product_sum_reg_o      <= product_sum_reg_q;
      multiply_unit_status_o <= multiply_unit_status_q;
      address_mask_o         <= address_mask_q;
    end
  end

endmodule

/* testbench/macd_unit_props.sv */
`timescale 1ns/1ps
module macd_unit_props (
  input wire logic                mclk_i,
  input wire logic                rst_i,
  input wire macd_pkg::macd_req_s req_i,
  input wire macd_pkg::macd_wb_s  wb_o,
  input wire macd_pkg::macd_cc_s  cc_o,
  input wire logic [31:0]         mem_addr_o,
  input wire logic                mem_addr_valid_o,
  input wire logic                illegal_o,
  input wire logic                done_o,
  input wire logic [31:0]         product_sum_reg_o,
  input wire logic [7:0]          multiply_unit_status_o,
  input wire logic [15:0]         address_mask_o
);
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  logic ld;
  logic md_ok;
  logic v;
  logic mv_ea;
  assign v = req_i.valid;
  assign ld = v && req_i.op[15:12] == 4'ha && req_i.op[8:7] == 2'h1;
  assign md_ok = req_i.op[5:3] inside {3'h2, 3'h3, 3'h4, 3'h5};
  assign mv_ea = req_i.op[5:4] == 2'h0 || req_i.op[5:0] == 6'h3c;
  sequence s_ld_wb;
    wb_o.we && wb_o.idx == {$past(req_i.op[6]), $past(req_i.op[11:9])} && wb_o.data == $past(req_i.ea_data);
  endsequence
  sequence s_ld_addr;
    mem_addr_valid_o && mem_addr_o[31:16] == $past(req_i.ea_addr[31:16]);
  endsequence
  a_load_dest: assert property (ld && md_ok |=> s_ld_wb and s_ld_addr)
    else $error("load write-back wrong");
  a_mask_and: assert property (ld && md_ok && req_i.ext[5] |=>
    mem_addr_o[15:0] == ($past(req_i.ea_addr[15:0]) & address_mask_o)) else $error("masked address wrong");
  a_bad_mode: assert property (ld && !md_ok |=> illegal_o && !done_o && !wb_o.we)
    else $error("bad mode accepted");
  a_not_line_a: assert property (v && req_i.op[15:12] != 4'ha |=> illegal_o && !done_o)
    else $error("foreign opcode accepted");
  a_from_acc: assert property (v && req_i.op[15:4] == 12'ha18 |=>
    wb_o.we && wb_o.idx == $past(req_i.op[3:0]) && wb_o.data == product_sum_reg_o) else $error("acc read wrong");
  a_from_stat: assert property (v && req_i.op[15:4] == 12'ha98 |=>
    wb_o.we && wb_o.data == {24'h0, multiply_unit_status_o}) else $error("status read wrong");
  a_ccr_copy: assert property (v && req_i.op == 16'ha9c0 |=>
    cc_o.we && cc_o.nzvc == multiply_unit_status_o[3:0] ##1 $stable(multiply_unit_status_o))
    else $error("cc copy wrong");
  a_to_acc: assert property (v && req_i.op[15:6] == 10'h284 && mv_ea |=> ##1
    product_sum_reg_o == $past(req_i.ea_data, 2) && multiply_unit_status_o[1:0] == 2'h0)
    else $error("acc load wrong");
  a_to_stat: assert property (v && req_i.op[15:6] == 10'h2a4 && mv_ea |=> ##1
    multiply_unit_status_o == ($past(req_i.ea_data[7:0], 2) & 8'hce)) else $error("status load wrong");
  a_from_mask: assert property (v && req_i.op[15:4] == 12'had8 |=>
    wb_o.we && wb_o.data == {16'hffff, address_mask_o}) else $error("mask read wrong");
  a_to_mask: assert property (v && req_i.op[15:6] == 10'h2b4 && mv_ea |=> ##1
    address_mask_o == $past(req_i.ea_data[15:0], 2)) else $error("mask load wrong");
endmodule
bind macd_unit macd_unit_props u_macd_unit_props (.mclk_i, .rst_i, .req_i, .wb_o, .cc_o, .mem_addr_o,
  .mem_addr_valid_o, .illegal_o, .done_o, .product_sum_reg_o, .multiply_unit_status_o, .address_mask_o);

/* testbench/macd_regfile.sv */
`timescale 1ns/1ps
module macd_regfile (
  input  wire logic               mclk_i,
  input  wire macd_pkg::macd_wb_s wb_i,
  input  wire logic [3:0]         rd_idx_i,
  output logic [31:0]             rd_data_o
);
  logic [31:0] regs_q [16];
  always_ff @(posedge mclk_i) begin
    if (wb_i.we) begin
      regs_q[wb_i.idx] <= wb_i.data;
    end
  end
  assign rd_data_o = regs_q[rd_idx_i];
endmodule

/* testbench/mac_unit_instruction_decode_test.sv */
`timescale 1ns/1ps
module mac_unit_instruction_decode_test;
  logic                mclk_i;
  logic                rst_i;
  macd_pkg::macd_req_s req_i;
  macd_pkg::macd_wb_s  wb_o;
  macd_pkg::macd_cc_s  cc_o;
  logic [31:0]         mem_addr_o;
  logic                mav;
  logic                illegal_o;
  logic                done_o;
  logic [31:0]         acc_o;
  logic [7:0]          stat_o;
  logic [15:0]         mask_o;
  logic [3:0]          rd_idx;
  logic [31:0]         rd_data;
  int                  miscompares;
  int                  checks;
  macd_unit u_macd_unit (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req_i), .wb_o(wb_o), .cc_o(cc_o),
    .mem_addr_o(mem_addr_o), .mem_addr_valid_o(mav), .illegal_o(illegal_o), .done_o(done_o),
    .product_sum_reg_o(acc_o), .multiply_unit_status_o(stat_o), .address_mask_o(mask_o));
  macd_regfile u_macd_regfile (.mclk_i(mclk_i), .wb_i(wb_o), .rd_idx_i(rd_idx), .rd_data_o(rd_data));
  initial begin
    mclk_i = 1'h0;
    forever #25 mclk_i = ~mclk_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // Issue one request with the address fixed at abcdffff
  task automatic issue(input logic [15:0] op, input logic [15:0] ext, input logic [31:0] x, input logic [31:0] y,
                       input logic [31:0] data);
    @(negedge mclk_i);
    req_i <= '{1'h1, op, ext, x, y, 32'habcdffff, data};
    @(posedge mclk_i);
    #1;
  endtask
  task automatic idle();
    @(negedge mclk_i);
    req_i.valid <= 1'h0;
    @(negedge mclk_i);
  endtask
  task automatic t_moves();
    logic [31:0] v [3] = '{32'h80000000, 32'h1, 32'h0};
    logic [15:0] o [3] = '{16'ha103, 16'ha10a, 16'ha13c};
    logic [7:0]  s [3] = '{8'h08, 8'h00, 8'h04};
    chk(acc_o, 32'h0, "acc rst");
    chk(mask_o, 16'hffff, "mask rst");
    for (int i = 0; i < 3; i++) begin
      issue(o[i], 16'h0, 0, 0, v[i]);
      issue(16'ha185, 16'h0, 0, 0, 0);
      chk(wb_o.data, v[i], "acc read");
      chk(wb_o.idx, 4'h5, "acc idx");
      idle();
      chk(stat_o, s[i], "acc flags");
    end
    issue(16'ha93c, 16'h0, 0, 0, 32'hff);
    issue(16'ha982, 16'h0, 0, 0, 0);
    chk(wb_o.data, 32'hce, "stat read");
    issue(16'ha9c0, 16'h0, 0, 0, 0);
    chk(cc_o.we, 1'h1, "cc we");
    chk(cc_o.nzvc, 4'he, "cc flags");
    issue(16'had3c, 16'h0, 0, 0, 32'h123400f0);
    issue(16'had81, 16'h0, 0, 0, 0);
    chk(wb_o.data, 32'hffff00f0, "mask read");
    idle();
    chk(mask_o, 16'h00f0, "mask");
    chk(stat_o, 8'hce, "stat kept");
    $display("test moves done");
  endtask
  task automatic t_load();
    logic [2:0] m;
    issue(16'ha13c, 16'h0, 0, 0, 32'h100);
    for (int i = 2; i < 6; i++) begin
      m = i[2:0];
      issue(16'ha6c1 | {10'h0, m, 3'h0}, {4'h7, 6'h20, m == 3'h5, 5'h01}, 32'h3, 32'h4, {29'h0, m});
      chk(done_o, 1'h1, "ld done");
      chk(mav, 1'h1, "ld valid");
      chk(wb_o.idx, 4'hb, "ld dest");
      chk(wb_o.data, {29'h0, m}, "ld data");
      chk(mem_addr_o, m == 3'h5 ? 32'habcd00f0 : 32'habcdffff, "ld addr");
    end
    for (int i = 0; i < 4; i++) begin
      m = {i[1], i[1], i[0]};
      issue(16'ha6c1 | {10'h0, m, 3'h0}, 16'h7801, 32'h3, 32'h4, 0);
      chk({illegal_o, done_o}, 2'h2, "bad mode");
    end
    issue(16'hb183, 16'h0, 0, 0, 0);
    chk({illegal_o, done_o}, 2'h2, "not line a");
    idle();
    chk(acc_o, 32'h130, "ld acc");
    chk(rd_data, 32'h5, "reg file");
    $display("test load done");
  endtask
  task automatic t_arith();
    issue(16'ha6d1, {4'h7, 6'h0f, 1'h0, 5'h01}, 32'h00050002, 32'h00030009, 0);
    issue(16'ha6d1, {4'h7, 6'h38, 1'h0, 5'h01}, 32'h8, 32'h4, 0);
    idle();
    chk(acc_o, 32'h122, "arith acc");
    chk(stat_o, 8'hc0, "arith flags");
    issue(16'ha13c, 16'h0, 0, 0, 32'h7fffffff);
    issue(16'ha201, 16'h0800, 32'h1, 32'h1, 0);
    chk({done_o, mav, wb_o.we}, 3'h4, "plain mac");
    issue(16'ha201, 16'h0800, 32'h1, 32'h1, 0);
    idle();
    chk(acc_o, 32'h80000001, "ovf acc");
    chk(stat_o, 8'hca, "ovf sticky");
    $display("test arith done");
  endtask
  task automatic results();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    $display("BAD %0t timeout", $time);
    results();
  end
  initial begin
    rst_i = 1'h1;
    req_i = '0;
    rd_idx = 4'hb;
    repeat (3) @(negedge mclk_i);
    rst_i <= 1'h0;
    t_moves();
    t_load();
    t_arith();
    results();
  end
endmodule
